// *** common/tester_bus_pkg.sv ***
package tester_bus_pkg;

   // ======================================================
   // bus geometry
   localparam int BUS_W            = 24;
   localparam int ADDR_LSB         = 8;
   localparam int ADDR_W           = 6;
   localparam int HOST_TO_ACC_BIT  = 16;
   localparam int ACC_XFER_BIT     = 17;
   localparam int UNIT_LSB         = 0;
   localparam int UNIT_W           = 7;
   localparam logic [6:0] UNIT_CODE = 7'h50;

   // ======================================================
   // address codes (octal codes written in hex)
   localparam logic [5:0] ADDR_NOOP_ZERO = 6'h00;
   localparam logic [5:0] ADDR_NOOP_ONES = 6'h3f;
   localparam int STAGE_N   = 6;
   localparam int LEVEL_N   = 16;
   localparam int COUNTER_N = 4;
   // order: mode, status, instruction, memory pointer, station control
   localparam logic [4:0][5:0] STAGE_ADDR = {6'h05, 6'h04, 6'h03, 6'h02, 6'h01};
   localparam int CONTROL_CARD_IDX = 5;
   // level register enables, index 15 first
   localparam logic [15:0][5:0] LEVEL_ADDR = {
      6'h13, 6'h14, 6'h24, 6'h25, 6'h15, 6'h12, 6'h16, 6'h11,
      6'h1c, 6'h1d, 6'h23, 6'h22, 6'h1a, 6'h1b, 6'h1e, 6'h1f};
   // burst count, delay count, step match, step number
   localparam logic [3:0][5:0] COUNTER_ADDR = {6'h0d, 6'h0c, 6'h09, 6'h08};

   // ======================================================
   // direct-memory steering
   localparam int STEER_LSB     = 21;
   localparam int STEER_W       = 3;
   localparam int PIN_REG_N     = 6;
   localparam int FIFO_DEPTH    = 8;

   // ======================================================
   // reset values
   localparam logic [5:0]  ADDR_RST = 6'h00;
   localparam logic [23:0] WORD_RST = 24'h000000;

   // ======================================================
   // types
   typedef enum logic [1:0]
   {
      OP_NONE    = 2'h0,
      OP_SPECIAL = 2'h1,
      OP_WRITE   = 2'h2,
      OP_READ    = 2'h3
   } xfer_op_t;

   typedef enum logic [3:0]
   {
      PH_IDLE = 4'h1,
      PH_T5   = 4'h2,
      PH_T1   = 4'h4,
      PH_T2   = 4'h8
   } phase_t;

endpackage

// *** common/word_stream_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface word_stream_if #(parameter int WIDTH = 24);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;

   modport source
   (
      output valid,
      output data,
      input  ready
   );

   modport sink
   (
      input  valid,
      input  data,
      output ready
   );
endinterface

`default_nettype wire

// *** verilog/word_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none

module word_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 8
)(
   input  wire logic          clock,
   input  wire logic          sys_rst,
   word_stream_if.sink        fill,
   word_stream_if.source      drain
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed
   {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wr;
      logic [PW-1:0]               rd;
      logic [CW-1:0]               count;
   } fifo_state_t;

   fifo_state_t s_q;
   fifo_state_t s_d;
   logic        push;
   logic        pop;

   // ======================================================
   // handshakes
   assign fill.ready  = (s_q.count != CW'(DEPTH));
   assign drain.valid = (s_q.count != '0);
   assign drain.data  = s_q.mem[s_q.rd];
   assign push        = fill.valid && fill.ready;
   assign pop         = drain.valid && drain.ready;

   always_comb
   begin
      s_d = s_q;
      if (push)
      begin
         s_d.mem[s_q.wr] = fill.data;
         s_d.wr = (s_q.wr == PW'(DEPTH - 1)) ? '0 : s_q.wr + 1'b1;
      end
      if (pop)
      begin
         s_d.rd = (s_q.rd == PW'(DEPTH - 1)) ? '0 : s_q.rd + 1'b1;
      end
      // simultaneous push and pop keep the count
      if (push && !pop)
      begin
         s_d.count = s_q.count + 1'b1;
      end
      else if (pop && !push)
      begin
         s_d.count = s_q.count - 1'b1;
      end
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end
endmodule

`default_nettype wire

// *** verilog/tester_register_bus_routing.sv ***
`timescale 1ns/1ps
`default_nettype none

module tester_register_bus_routing
(
   input  wire logic                    clock,
   input  wire logic                    sys_rst,
   input  wire logic [23:0]             host_bus_in,
   output logic      [23:0]             host_bus_out,
   output logic                         host_bus_oe,
   input  wire logic                    device_select,
   input  wire logic                    dma_write_strobe,
   output logic                         dma_ready,
   output logic      [23:0]             short_register_bus,
   output tester_bus_pkg::xfer_op_t     transfer_op,
   output logic      [5:0]              stage_enable,
   output logic      [15:0]             level_enable,
   output logic      [3:0]              counter_enable,
   input  wire logic [23:0]             short_read_data,
   output logic      [23:0]             long_register_bus,
   output logic                         long_valid,
   input  wire logic                    long_ready,
   output logic      [5:0]              per_pin_select,
   output logic                         special_select
);

   // ======================================================
   // state
   typedef struct packed
   {
      logic [23:0]              bus_s1;
      logic [23:0]              bus_s2;
      logic                     sel_s1;
      logic                     sel_s2;
      logic                     sel_prev;
      logic                     dma_s1;
      logic                     dma_s2;
      logic                     dma_prev;
      tester_bus_pkg::phase_t   phase;
      logic [5:0]               addr;
      tester_bus_pkg::xfer_op_t op;
      logic [5:0]               stage_en;
      logic [15:0]              level_en;
      logic [3:0]               counter_en;
      logic [23:0]              srb;
      logic [23:0]              rd_data;
      logic                     rd_oe;
      logic [23:0]              long_word;
      logic                     long_valid;
      logic [5:0]               pin_sel;
      logic                     special_sel;
   } state_t;

   localparam state_t STATE_RST = '{
      phase   : tester_bus_pkg::PH_IDLE,
      op      : tester_bus_pkg::OP_NONE,
      addr    : tester_bus_pkg::ADDR_RST,
      srb     : tester_bus_pkg::WORD_RST,
      default : '0
   };

   state_t s_q;
   state_t s_d;

   logic                     sel_rise;
   logic                     dma_rise;
   logic                     unit_ok;
   logic                     addr_noop;
   logic [5:0]               stage_hit;
   logic [15:0]              level_hit;
   logic [3:0]               counter_hit;
   logic                     claimed;
   logic [2:0]               steer;
   logic [4:0]               stage_raw;
   logic [15:0]              level_raw;
   logic [3:0]               counter_raw;
   logic [5:0]               steer_pins;
   logic                     steer_special;
   logic                     take_cmd;
   logic                     read_claim;
   logic [5:0]               cmd_addr;
   tester_bus_pkg::xfer_op_t cmd_op;

   // ======================================================
   // buffer stage and fifo carriers
   word_stream_if #(.WIDTH(tester_bus_pkg::BUS_W)) fill_if ();
   word_stream_if #(.WIDTH(tester_bus_pkg::BUS_W)) drain_if ();

   // instruction register path: holds dma words until the receiver takes them
   word_fifo #(
      .WIDTH (tester_bus_pkg::BUS_W),
      .DEPTH (tester_bus_pkg::FIFO_DEPTH)
   ) u_instr_fifo (
      .clock   (clock),
      .sys_rst (sys_rst),
      .fill    (fill_if.sink),
      .drain   (drain_if.source)
   );

   // ======================================================
   // edges and qualifiers
   // edges are taken on the second sync stage only
   assign sel_rise = s_q.sel_s2 && !s_q.sel_prev;
   assign dma_rise = s_q.dma_s2 && !s_q.dma_prev;

   assign unit_ok = (s_q.bus_s2[tester_bus_pkg::UNIT_LSB +: tester_bus_pkg::UNIT_W]
                     == tester_bus_pkg::UNIT_CODE);

   assign addr_noop = (s_q.addr == tester_bus_pkg::ADDR_NOOP_ZERO) ||
                      (s_q.addr == tester_bus_pkg::ADDR_NOOP_ONES);

   // the bus is synchronised bit by bit, so the host holds it steady around select
   // address field of the selected word
   assign cmd_addr = s_q.bus_s2[tester_bus_pkg::ADDR_LSB +: tester_bus_pkg::ADDR_W];
   assign cmd_op   = tester_bus_pkg::xfer_op_t'({s_q.bus_s2[tester_bus_pkg::ACC_XFER_BIT],
                                                 s_q.bus_s2[tester_bus_pkg::HOST_TO_ACC_BIT]});

   // select edges outside idle are dropped; the host must not overlap commands
   assign take_cmd = sel_rise && unit_ok && (s_q.phase == tester_bus_pkg::PH_IDLE);

   // ======================================================
   // address decode over the three groups: stages, levels, counters
   // address stage decode
   for (genvar i = 0; i < 5; i++)
   begin
      assign stage_raw[i] = (s_q.addr == tester_bus_pkg::STAGE_ADDR[i]);
   end

   for (genvar i = 0; i < tester_bus_pkg::LEVEL_N; i++)
   begin
      assign level_raw[i] = (s_q.addr == tester_bus_pkg::LEVEL_ADDR[i]);
   end

   for (genvar i = 0; i < tester_bus_pkg::COUNTER_N; i++)
   begin
      assign counter_raw[i] = (s_q.addr == tester_bus_pkg::COUNTER_ADDR[i]);
   end

   always_comb
   begin
      stage_hit   = '0;
      level_hit   = '0;
      counter_hit = '0;
      if (!addr_noop)
      begin
         // the control card is selected whenever one of its codes matches
         stage_hit[4:0] = stage_raw;
         stage_hit[tester_bus_pkg::CONTROL_CARD_IDX] = |level_raw;
         level_hit   = level_raw;
         counter_hit = counter_raw;
      end
   end

   assign claimed = (|stage_hit) || (|counter_hit);
   // a read of an unclaimed code leaves the host bus undriven
   assign read_claim = (s_q.op == tester_bus_pkg::OP_READ) && claimed;

   assign steer = drain_if.data[tester_bus_pkg::STEER_LSB +: tester_bus_pkg::STEER_W];

   // ======================================================
   // line receiver steering
   // codes past the last pin register all land on the special group
   always_comb
   begin
      steer_pins    = '0;
      steer_special = 1'b0;
      if (steer < 3'(tester_bus_pkg::PIN_REG_N))
      begin
         steer_pins[steer] = 1'b1;
      end
      else
      begin
         steer_special = 1'b1;
      end
   end

   // ======================================================
   // dma handshakes
   // second sync stage of the host bus straight into instruction fifo
   assign fill_if.valid  = dma_rise;
   assign fill_if.data   = s_q.bus_s2;
   // a strobe while the fifo is full is dropped; the host watches dma_ready
   assign dma_ready      = fill_if.ready;
   // line driver stalls the fifo while the receiver still holds a word
   assign drain_if.ready = !s_q.long_valid || long_ready;

   // ======================================================
   // next state
   always_comb
   begin
      s_d = s_q;

      // two-stage synchronisers for the pins
      s_d.bus_s1   = host_bus_in;
      s_d.bus_s2   = s_q.bus_s1;
      s_d.sel_s1   = device_select;
      s_d.sel_s2   = s_q.sel_s1;
      s_d.sel_prev = s_q.sel_s2;
      s_d.dma_s1   = dma_write_strobe;
      s_d.dma_s2   = s_q.dma_s1;
      s_d.dma_prev = s_q.dma_s2;

      // buffer stage mirrors the host bus
      s_d.srb = s_q.bus_s2;

      case (s_q.phase)
         tester_bus_pkg::PH_IDLE:
         begin
            // address stage always listens, no select code of its own
            // accept only on select with the unit code
            if (take_cmd)
            begin
               s_d.addr  = cmd_addr;
               s_d.op    = cmd_op;
               s_d.phase = tester_bus_pkg::PH_T5;
            end
         end

         tester_bus_pkg::PH_T5:
         begin
            // enables come only from the command sequence
            if (s_q.op != tester_bus_pkg::OP_NONE)
            begin
               s_d.stage_en   = stage_hit;
               s_d.level_en   = level_hit;
               s_d.counter_en = counter_hit;
            end
            // read drives the host bus only for a claimed register
            s_d.rd_oe   = read_claim;
            s_d.rd_data = short_read_data;
            s_d.phase   = tester_bus_pkg::PH_T1;
         end

         tester_bus_pkg::PH_T1:
         begin
            s_d.rd_data = short_read_data;
            s_d.phase   = tester_bus_pkg::PH_T2;
         end

         tester_bus_pkg::PH_T2:
         begin
            // clear address and enables, ready for next command
            s_d.addr       = tester_bus_pkg::ADDR_RST;
            s_d.op         = tester_bus_pkg::OP_NONE;
            s_d.stage_en   = '0;
            s_d.level_en   = '0;
            s_d.counter_en = '0;
            s_d.rd_oe      = 1'b0;
            s_d.phase      = tester_bus_pkg::PH_IDLE;
         end

         default:
         begin
            // an illegal phase drops the command rather than guess where it was
            s_d.addr       = tester_bus_pkg::ADDR_RST;
            s_d.op         = tester_bus_pkg::OP_NONE;
            s_d.stage_en   = '0;
            s_d.level_en   = '0;
            s_d.counter_en = '0;
            s_d.rd_oe      = 1'b0;
            s_d.phase      = tester_bus_pkg::PH_IDLE;
         end
      endcase

      // line receiver
      if (drain_if.valid && drain_if.ready)
      begin
         s_d.long_word   = drain_if.data;
         s_d.long_valid  = 1'b1;
         s_d.pin_sel     = steer_pins;
         s_d.special_sel = steer_special;
      end
      else if (long_ready)
      begin
         s_d.long_valid  = 1'b0;
         s_d.pin_sel     = '0;
         s_d.special_sel = 1'b0;
      end
   end

   // ======================================================
   // registers
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         s_q <= STATE_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ======================================================
   // outputs
   // three separate buses: host, short register, long register
   assign short_register_bus = s_q.srb;
   assign long_register_bus  = s_q.long_word;
   assign long_valid         = s_q.long_valid;
   assign per_pin_select     = s_q.pin_sel;
   assign special_select     = s_q.special_sel;
   // mode and status see the host words through the address stage enables
   assign stage_enable       = s_q.stage_en;
   assign level_enable       = s_q.level_en;
   assign counter_enable     = s_q.counter_en;
   assign transfer_op        = s_q.op;
   // short_read_data from the last command of any op stays on host_bus_out; only host_bus_oe marks it valid
   assign host_bus_out       = s_q.rd_data;
   assign host_bus_oe        = s_q.rd_oe;

endmodule

`default_nettype wire

// *** sim/routing_properties.sv ***
`timescale 1ns/1ps
`default_nettype none

// ==========
// routing checker
module routing_properties
(
   input  wire logic                     clock,
   input  wire logic                     sys_rst,
   input  wire logic [23:0]              host_bus_in,
   input  wire logic                     host_bus_oe,
   input  wire logic [23:0]              short_register_bus,
   input  wire tester_bus_pkg::xfer_op_t transfer_op,
   input  wire logic [5:0]               stage_enable,
   input  wire logic [15:0]              level_enable,
   input  wire logic [3:0]               counter_enable,
   input  wire logic [23:0]              long_register_bus,
   input  wire logic                     long_valid,
   input  wire logic                     long_ready,
   input  wire logic [5:0]               per_pin_select,
   input  wire logic                     special_select
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);

   logic [25:0] any_en;
   assign any_en = {stage_enable, level_enable, counter_enable};

   a_bus_mirror:
   assert property (!$past(sys_rst, 3) && !$past(sys_rst, 2) && !$past(sys_rst)
      |-> short_register_bus == $past(host_bus_in, 3)) else $error("short bus not a mirror");
   a_enable_two:
   assert property ($rose(|any_en) |=> $stable(any_en) ##1 any_en == 26'h0)
      else $error("enable width wrong");
   a_one_enable:
   assert property ($onehot0({stage_enable[4:0], level_enable, counter_enable}))
      else $error("two registers enabled");
   a_card_level:
   assert property (|level_enable |-> stage_enable[5]) else $error("control card idle");
   a_read_drive:
   assert property (host_bus_oe |-> |any_en && (transfer_op == tester_bus_pkg::OP_READ
      || $past(transfer_op) == tester_bus_pkg::OP_READ)) else $error("bus driven off read");
   a_none_quiet:
   assert property (transfer_op == tester_bus_pkg::OP_NONE
      && $past(transfer_op) == tester_bus_pkg::OP_NONE |-> any_en == 26'h0 && !host_bus_oe)
      else $error("enable without operation");
   a_long_hold:
   assert property (long_valid && !long_ready |=> long_valid && $stable(long_register_bus)
      && $stable({per_pin_select, special_select})) else $error("long word dropped");
   a_steer_word:
   assert property (long_valid |-> {per_pin_select, special_select} ==
      (long_register_bus[23:22] == 2'h3 ? 7'h01 : {6'h01 << long_register_bus[23:21], 1'b0}))
      else $error("steering wrong");

   c_level: cover property ($rose(|level_enable));
   c_read: cover property ($rose(host_bus_oe));
   c_stall: cover property (long_valid && !long_ready ##1 long_ready);
endmodule

bind tester_register_bus_routing routing_properties chk
(
   .clock(clock), .sys_rst(sys_rst), .host_bus_in(host_bus_in), .host_bus_oe(host_bus_oe),
   .short_register_bus(short_register_bus), .transfer_op(transfer_op),
   .stage_enable(stage_enable), .level_enable(level_enable), .counter_enable(counter_enable),
   .long_register_bus(long_register_bus), .long_valid(long_valid), .long_ready(long_ready),
   .per_pin_select(per_pin_select), .special_select(special_select)
);

`default_nettype wire

// *** sim/host_card_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ==========
// host interface card
module host_card_model
(
   input  wire logic  clock,
   output logic [23:0] host_bus_in,
   output logic        device_select,
   output logic        dma_write_strobe
);
   initial
   begin
      host_bus_in = 24'h000000;
      device_select = 1'b0;
      dma_write_strobe = 1'b0;
   end

   // one programmed command
   // bus held from before select until after it drops, as the sync flops need
   task automatic command(input logic [23:0] word);
      host_bus_in <= word;
      repeat (3) @(posedge clock);
      device_select <= 1'b1;
      repeat (8) @(posedge clock);
      device_select <= 1'b0;
      repeat (3) @(posedge clock);
   endtask

   task automatic dma_push(input logic [23:0] word);
      host_bus_in <= word;
      repeat (3) @(posedge clock);
      dma_write_strobe <= 1'b1;
      repeat (2) @(posedge clock);
      dma_write_strobe <= 1'b0;
      repeat (4) @(posedge clock);
   endtask
endmodule

`default_nettype wire

// *** sim/tester_register_bus_routing_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) \
      begin \
         n_mismatch++; \
         $display("wrong value at %0t: output differs", $time); \
      end \
   end

module tester_register_bus_routing_tb;
   logic                     clock;
   logic                     sys_rst;
   logic [23:0]              host_bus_in, host_bus_out, short_register_bus;
   logic [23:0]              short_read_data, long_register_bus, w, rd;
   logic                     device_select, dma_write_strobe, host_bus_oe, dma_ready;
   logic                     long_valid, long_ready, special_select, seen, drain;
   tester_bus_pkg::xfer_op_t transfer_op;
   logic [5:0]               stage_enable, per_pin_select;
   logic [15:0]              level_enable;
   logic [3:0]               counter_enable;
   logic [52:0]              act, e;
   logic [52:0]              cmd_q[$];
   logic [30:0]              dma_q[$];
   int                       n_mismatch, tests_run, n_acc;

   host_card_model host (.clock(clock), .host_bus_in(host_bus_in),
      .device_select(device_select), .dma_write_strobe(dma_write_strobe));

   tester_register_bus_routing dut (.clock(clock), .sys_rst(sys_rst),
      .host_bus_in(host_bus_in), .host_bus_out(host_bus_out), .host_bus_oe(host_bus_oe),
      .device_select(device_select), .dma_write_strobe(dma_write_strobe),
      .dma_ready(dma_ready), .short_register_bus(short_register_bus),
      .transfer_op(transfer_op), .stage_enable(stage_enable), .level_enable(level_enable),
      .counter_enable(counter_enable), .short_read_data(short_read_data),
      .long_register_bus(long_register_bus), .long_valid(long_valid),
      .long_ready(long_ready), .per_pin_select(per_pin_select),
      .special_select(special_select));

   // ==========
   // clock and expectations
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   function automatic logic [52:0] expect_cmd(input logic [1:0] op, input logic [5:0] a,
                                              input logic [23:0] r);
      logic [5:0]  st;
      logic [15:0] lv;
      logic [3:0]  ct;
      logic        oe;
      st = 6'h00;
      lv = 16'h0000;
      ct = 4'h0;
      for (int i = 0; i < 5; i++) st[i] = tester_bus_pkg::STAGE_ADDR[i] == a;
      for (int i = 0; i < 16; i++) lv[i] = tester_bus_pkg::LEVEL_ADDR[i] == a;
      for (int i = 0; i < 4; i++) ct[i] = tester_bus_pkg::COUNTER_ADDR[i] == a;
      st[5] = |lv;
      oe = op == 2'h3 && |{st, lv, ct};
      if (op == 2'h0)
         return 53'h0;
      return {op, st, lv, ct, oe, oe ? r : 24'h000000};
   endfunction

   // ==========
   // result watcher
   always @(posedge clock)
   begin
      act = {transfer_op, stage_enable, level_enable, counter_enable, host_bus_oe,
             host_bus_oe ? host_bus_out : 24'h000000};
      if (!sys_rst && |act[50:24] && !seen)
      begin
         if (cmd_q.size() == 0) `CHK(act, 53'h0)
         else `CHK(act, cmd_q.pop_front())
      end
      seen <= |act[50:24];
      if (long_valid && long_ready)
      begin
         if (dma_q.size() == 0) `CHK(long_valid, 1'b0)
         else `CHK({long_register_bus, per_pin_select, special_select}, dma_q.pop_front())
      end
      long_ready <= drain ? 1'($urandom) : 1'b0;
   end

   task automatic give_verdict();
      $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      #500000;
      n_mismatch++;
      give_verdict();
   end

   // ==========
   // main sequence
   initial
   begin
      sys_rst = 1'b1;
      short_read_data = 24'h000000;
      long_ready = 1'b0;
      drain = 1'b0;
      seen = 1'b0;
      void'($urandom(52));
      repeat (6) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (3) @(posedge clock);
      `CHK({dma_ready, long_valid}, 2'h2)
      // every code with every operation; a few with a foreign unit
      for (int k = 0; k < 260; k++)
      begin
         rd = 24'($urandom);
         w = 24'($urandom);
         w[17:16] = k < 256 ? k[1:0] : 2'h2;
         w[13:8] = k < 256 ? k[7:2] : tester_bus_pkg::STAGE_ADDR[k[1:0]];
         w[6:0] = k < 256 ? tester_bus_pkg::UNIT_CODE
                          : tester_bus_pkg::UNIT_CODE ^ (7'h01 << k[1:0]);
         short_read_data <= rd;
         e = expect_cmd(w[17:16], w[13:8], rd);
         if (|e[50:24] && k < 256)
            cmd_q.push_back(e);
         host.command(w);
      end
      // fill while stalled, then overflow is refused
      for (int k = 0; k < 11; k++)
      begin
         w = 24'($urandom);
         w[23:21] = k[2:0];
         if (dma_ready)
         begin
            n_acc++;
            dma_q.push_back({w, w[23:22] == 2'h3 ? 7'h01 : {6'h01 << w[23:21], 1'b0}});
         end
         host.dma_push(w);
      end
      `CHK({n_acc, dma_ready}, {32'd9, 1'b0})
      drain <= 1'b1;
      repeat (200) @(posedge clock);
      `CHK({cmd_q.size(), dma_q.size(), long_valid, dma_ready}, {64'd0, 2'h1})
      give_verdict();
   end
endmodule

`default_nettype wire
